// ### core/clock_sync_serial_channel.sv
// clock synchronous serial channel with transmit fifo

// ---------------------------------------------------------------
// transmit fifo
// ---------------------------------------------------------------
module sync_serial_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_r];

  // storage only, no reset needed
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data_i;
  end

  // pointers, count and registered full/empty
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
        in_ready_o <= (count_r != (AW + 1)'(DEPTH - 1));
        out_valid_o <= 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
        in_ready_o <= 1'b1;
        out_valid_o <= (count_r != (AW + 1)'(1));
      end
    end
  end
endmodule : sync_serial_fifo

// ---------------------------------------------------------------
// serial channel
// ---------------------------------------------------------------
module clock_sync_serial_channel
  import sync_serial_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire cfg_t cfg_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic rx_read_i,
  output logic [7:0] rx_buffer_reg_o,
  output status_t status_o,
  output logic tx_irq_o,
  output logic rx_irq_o,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  output logic serial_clock_alt_o,
  output logic serial_clock_alt_oe_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o,
  input wire logic cts_n_i,
  output logic rts_n_o,
  output logic rts_n_oe_o,
  output logic pin_group_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // prescaled source tick for the selected divide
  function automatic logic src_tick(input logic [1:0] sel, input logic [4:0] cnt);
    unique case (sel)
      SRC_DIV1: src_tick = 1'b1;
      SRC_DIV2: src_tick = ((cnt & DIV2_MASK) == DIV2_MASK);
      SRC_DIV8: src_tick = ((cnt & DIV8_MASK) == DIV8_MASK);
      SRC_DIV32: src_tick = ((cnt & DIV32_MASK) == DIV32_MASK);
    endcase
  endfunction : src_tick

  // next outgoing bit for the chosen order
  function automatic logic out_bit(input logic [7:0] sh, input logic msb);
    out_bit = msb ? sh[7] : sh[0];
  endfunction : out_bit

  // shift a bit into a word in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic msb);
    shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
  endfunction : shift_in

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  state_t state_r;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic [7:0] tx_buffer_reg_r;
  logic tx_empty_r;
  logic [7:0] tx_shift_r;
  logic [7:0] rx_shift_r;
  logic [2:0] bit_cnt_r;
  logic rx_active_r;
  logic rx_full_r;
  logic overrun_r;
  logic cont_pending_r;
  logic [4:0] presc_r;
  logic [7:0] brg_r;
  logic sclk_r;
  logic sclk_prev_r;
  logic txd_level_r;
  logic idle_level;
  logic half_tick;
  logic drive_edge;
  logic sample_edge;
  logic cts_used;
  logic rts_used;
  logic cts_ok;
  logic tx_start;
  logic cont_start;
  logic start;
  logic load;
  logic rx_bit;
  logic last_sample;
  logic inv;

  assign inv = (CHANNEL == 2) && cfg_i.invert_data;

  // ---------------------------------------------------------------
  // transmit buffer fed from the fifo
  // ---------------------------------------------------------------
  // fifo only drains while the buffer is empty, so a slow link
  // back-pressures the writer through tx_ready_o
  assign fifo_ready = tx_empty_r;

  sync_serial_fifo #(
    .WIDTH(FRAME_BITS),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready)
  );

  // ---------------------------------------------------------------
  // start conditions
  // ---------------------------------------------------------------
  // handshake mode decode
  assign cts_used = cfg_i.handshake_enable &&
                    (!cfg_i.handshake_rts || ((CHANNEL == 0) && cfg_i.separate_cts_rts));
  assign rts_used = cfg_i.handshake_enable &&
                    (cfg_i.handshake_rts || ((CHANNEL == 0) && cfg_i.separate_cts_rts));
  assign cts_ok = !cts_used || !cts_n_i;
  assign tx_start = cfg_i.tx_enable_flag && !tx_empty_r && cts_ok;
  assign cont_start = cfg_i.continuous_rx && cfg_i.rx_enable_flag &&
                      cfg_i.tx_enable_flag && cont_pending_r && cts_ok;
  assign start = (state_r == ST_IDLE) && (tx_start || cont_start);
  // buffer word moves into the shift register
  assign load = tx_start && (state_r == ST_IDLE || last_sample);

  // ---------------------------------------------------------------
  // transfer clock edges
  // ---------------------------------------------------------------
  // idle high for polarity 0, low for 1
  assign idle_level = !cfg_i.clock_edge_polarity;
  assign half_tick = src_tick(cfg_i.prescale_select, presc_r) && (brg_r == DIVIDER_RESET);
  // pin clock edges when source select is high
  always_comb
  begin
    if (cfg_i.clock_source_select)
    begin
      // drive edge moves away from idle level
      drive_edge = (serial_clock_pin_i != sclk_prev_r) &&
                   (serial_clock_pin_i == cfg_i.clock_edge_polarity);
      sample_edge = (serial_clock_pin_i != sclk_prev_r) &&
                    (serial_clock_pin_i == idle_level);
    end
    else
    begin
      drive_edge = half_tick && (sclk_r == idle_level);
      sample_edge = half_tick && (sclk_r != idle_level);
    end
  end
  assign rx_bit = rxd_i ^ inv;
  // eighth sampled bit ends the frame
  assign last_sample = sample_edge && (bit_cnt_r == LAST_BIT_IDX);

  // prescaler for the source selection, free running
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      presc_r <= PRESCALE_RESET;
    else
      presc_r <= presc_r + 1'b1;
  end

  // divider counts n+1 source ticks per half period
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      brg_r <= DIVIDER_RESET;
      sclk_r <= 1'b1;
    end
    else if (state_r == ST_IDLE || cfg_i.clock_source_select)
    begin
      brg_r <= cfg_i.bit_rate_divider;
      sclk_r <= idle_level;
    end
    else if (src_tick(cfg_i.prescale_select, presc_r))
    begin
      if (brg_r == DIVIDER_RESET)
      begin
        brg_r <= cfg_i.bit_rate_divider;
        sclk_r <= !sclk_r;
      end
      else
        brg_r <= brg_r - 1'b1;
    end
  end

  // pin clock history; unreset so no false edge follows reset
  always_ff @(posedge clock_i)
  begin
    sclk_prev_r <= serial_clock_pin_i;
  end

  // ---------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      state_r <= ST_IDLE;
    else
      unique case (state_r)
        ST_IDLE:
          if (start)
            state_r <= ST_SHIFT;
        ST_SHIFT:
          // chain next word without idle gap
          if (last_sample && !tx_start)
            state_r <= ST_IDLE;
      endcase
  end

  // transmit buffer and its empty flag
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_buffer_reg_r <= DATA_RESET;
      tx_empty_r <= 1'b1;
    end
    else if (load)
      tx_empty_r <= 1'b1;
    else if (fifo_valid && tx_empty_r)
    begin
      tx_buffer_reg_r <= fifo_data;
      tx_empty_r <= 1'b0;
    end
  end

  // shift registers and bit counter
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_shift_r <= DATA_RESET;
      rx_shift_r <= DATA_RESET;
      bit_cnt_r <= '0;
      txd_level_r <= 1'b1;
      rx_active_r <= 1'b0;
    end
    else if (load)
    begin
      // dummy word loads even when only receiving
      tx_shift_r <= tx_buffer_reg_r;
      bit_cnt_r <= '0;
      // reception joins a transmit start when its enable flag is set
      rx_active_r <= cfg_i.rx_enable_flag;
      if (last_sample)
        rx_shift_r <= shift_in(rx_shift_r, rx_bit, cfg_i.msb_first);
    end
    else if (start)
    begin
      // continuous receive reuses the last word as dummy data
      bit_cnt_r <= '0;
      rx_active_r <= 1'b1;
    end
    else if (state_r == ST_SHIFT)
    begin
      if (drive_edge)
      begin
        txd_level_r <= out_bit(tx_shift_r, cfg_i.msb_first) ^ inv;
        tx_shift_r <= cfg_i.msb_first ? {tx_shift_r[6:0], tx_shift_r[7]}
                                      : {tx_shift_r[0], tx_shift_r[7:1]};
      end
      if (sample_edge)
      begin
        rx_shift_r <= shift_in(rx_shift_r, rx_bit, cfg_i.msb_first);
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
    end
    // transmit level returns high between frames
    else
      txd_level_r <= 1'b1;
  end

  // ---------------------------------------------------------------
  // receive buffer, overrun and continuous restart
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rx_buffer_reg_o <= DATA_RESET;
      rx_full_r <= 1'b0;
      overrun_r <= 1'b0;
      cont_pending_r <= 1'b0;
    end
    else
    begin
      // seventh bit with unread buffer is overrun
      if (state_r == ST_SHIFT && rx_active_r && sample_edge &&
          bit_cnt_r == OVERRUN_BIT_IDX && rx_full_r && !rx_read_i)
        overrun_r <= 1'b1;
      else if (!cfg_i.rx_enable_flag)
        overrun_r <= 1'b0;
      // completed word moves to the buffer; set beats read
      if (state_r == ST_SHIFT && rx_active_r && last_sample)
      begin
        rx_buffer_reg_o <= shift_in(rx_shift_r, rx_bit, cfg_i.msb_first);
        rx_full_r <= 1'b1;
      end
      else if (rx_read_i)
        rx_full_r <= 1'b0;
      // read arms next reception, start consumes it
      if (rx_read_i && cfg_i.continuous_rx)
        cont_pending_r <= 1'b1;
      else if (start || !cfg_i.continuous_rx)
        cont_pending_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // request pulses
  // ---------------------------------------------------------------
  // the per-channel source bit arrives as tx_irq_source_select
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
    end
    else
    begin
      // buffer to shift register raises request, or frame end for source 1
      tx_irq_o <= cfg_i.tx_irq_source_select ? (state_r == ST_SHIFT && last_sample) : load;
      rx_irq_o <= state_r == ST_SHIFT && rx_active_r && last_sample &&
                  !(rx_full_r && !rx_read_i);
    end
  end

  // ---------------------------------------------------------------
  // pins and status, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      txd_o <= 1'b1;
      txd_oe_o <= 1'b0;
      serial_clock_pin_o <= 1'b1;
      serial_clock_pin_oe_o <= 1'b0;
      serial_clock_alt_o <= 1'b1;
      serial_clock_alt_oe_o <= 1'b0;
      rts_n_o <= 1'b1;
      rts_n_oe_o <= 1'b0;
      pin_group_o <= 1'b0;
      status_o <= '0;
    end
    else
    begin
      // open drain floats for a high level
      txd_o <= txd_level_r;
      txd_oe_o <= cfg_i.open_drain ? !txd_level_r : 1'b1;
      // channel 1 routes clock to either pin
      serial_clock_pin_o <= sclk_r;
      serial_clock_alt_o <= sclk_r;
      serial_clock_pin_oe_o <= !cfg_i.clock_source_select &&
                               !((CHANNEL == 1) && cfg_i.multi_clock_pins &&
                                 cfg_i.clock_pin_select);
      serial_clock_alt_oe_o <= !cfg_i.clock_source_select && (CHANNEL == 1) &&
                               cfg_i.multi_clock_pins && cfg_i.clock_pin_select;
      // rts drives its pin only while rts is in use; beside cts only on channel 0 with separate_cts_rts
      rts_n_o <= !(cfg_i.rx_enable_flag && !rx_full_r);
      rts_n_oe_o <= rts_used;
      pin_group_o <= (CHANNEL == 1) && cfg_i.pin_remap;
      status_o.tx_buffer_empty_flag <= tx_empty_r;
      status_o.tx_shift_empty <= (state_r == ST_IDLE);
      status_o.rx_full <= rx_full_r;
      status_o.overrun <= overrun_r;
    end
  end

endmodule : clock_sync_serial_channel

// ### core/sync_serial_pkg.sv
// shared types and constants of the clock synchronous serial channel
package sync_serial_pkg;

  // ------------
  // frame and buffering
  // ------------
  localparam int FRAME_BITS = 8;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam logic [2:0] OVERRUN_BIT_IDX = 3'h6;
  localparam int TX_FIFO_DEPTH = 8;

  // ------------
  // prescaled clock source selection
  // ------------
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_DIV8 = 2'h2;
  localparam logic [1:0] SRC_DIV32 = 2'h3;
  localparam logic [4:0] DIV2_MASK = 5'h01;
  localparam logic [4:0] DIV8_MASK = 5'h07;
  localparam logic [4:0] DIV32_MASK = 5'h1f;

  // ------------
  // reset values
  // ------------
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h00;
  localparam logic [4:0] PRESCALE_RESET = 5'h00;

  // configuration bits set by software
  typedef struct packed {
    logic clock_source_select;  // 0 internal, 1 from pin
    logic [1:0] prescale_select;
    logic [7:0] bit_rate_divider;
    logic handshake_enable;
    logic handshake_rts;        // 0 cts input, 1 rts output
    logic separate_cts_rts;     // channel 0 only
    logic open_drain;
    logic clock_edge_polarity;
    logic msb_first;
    logic tx_irq_source_select; // 0 buffer empty, 1 transfer done
    logic continuous_rx;
    logic invert_data;          // channel 2 only
    logic multi_clock_pins;     // channel 1 only
    logic clock_pin_select;     // channel 1 only
    logic pin_remap;            // channel 1 only
    logic tx_enable_flag;
    logic rx_enable_flag;
  } cfg_t;

  // status shown to software
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_shift_empty;
    logic rx_full;
    logic overrun;
  } status_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} state_t;

endpackage : sync_serial_pkg

// ### test/clock_sync_serial_channel_assertions.sv
// concurrent checks on the serial channel ports
module clock_sync_serial_channel_assertions
  import sync_serial_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire cfg_t cfg_i,
  input wire status_t status_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic txd_o,
  input wire logic txd_oe_o,
  input wire logic cts_n_i,
  input wire logic rts_n_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // ------------
  // half period counter of the generated clock
  // ------------
  logic last_r;
  logic armed_r;
  logic [8:0] cnt_r;
  logic chg;
  assign chg = serial_clock_pin_o != last_r;

  // cycles since last toggle, minus one
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      last_r <= 1'b1;
      cnt_r <= 9'h000;
    end
    else
    begin
      last_r <= serial_clock_pin_o;
      cnt_r <= chg ? 9'h000 : cnt_r + 9'h001;
    end
  end

  // armed on leaving idle, so idle gaps go unmeasured
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      armed_r <= 1'b0;
    else if (chg)
      armed_r <= serial_clock_pin_o == cfg_i.clock_edge_polarity;
  end

  // ------------
  // properties
  // ------------
  reset_idle_a: assert property ($fell(rst_i) |-> txd_o && !txd_oe_o && !tx_irq_o && !rx_irq_o)
    else $error("reset not idle");
  tx_pulse_a: assert property (tx_irq_o |=> !tx_irq_o)
    else $error("tx pulse too long");
  rx_pulse_a: assert property (rx_irq_o |=> !rx_irq_o)
    else $error("rx pulse too long");
  rx_refused_a: assert property ((!cfg_i.rx_enable_flag) [*3] |-> !rx_irq_o)
    else $error("rx irq while disabled");
  half_period_a: assert property (chg && armed_r && serial_clock_pin_oe_o
    && !cfg_i.clock_source_select && cfg_i.prescale_select == SRC_DIV1
    && serial_clock_pin_o != cfg_i.clock_edge_polarity |-> cnt_r == {1'b0, cfg_i.bit_rate_divider})
    else $error("bad half period");
  done_irq_a: assert property (rx_irq_o && cfg_i.tx_irq_source_select |-> tx_irq_o)
    else $error("tx irq not at end");
  start_irq_a: assert property (tx_irq_o && !cfg_i.tx_irq_source_select
    |-> ##[0:2] !status_o.tx_shift_empty)
    else $error("tx irq without start");
  cts_hold_a: assert property (cfg_i.handshake_enable && !cfg_i.handshake_rts && cts_n_i
    && $past(cts_n_i) && $past(cts_n_i, 2) && status_o.tx_shift_empty && !cfg_i.continuous_rx
    |=> status_o.tx_shift_empty)
    else $error("start while cts high");
  rts_idle_a: assert property ((cfg_i.handshake_enable && cfg_i.handshake_rts
    && !cfg_i.rx_enable_flag) [*2] |=> rts_n_o)
    else $error("rts low while rx off");

  // main scenarios reached
  cover property (rx_irq_o && cfg_i.msb_first);
  cover property (status_o.overrun);
  cover property (rx_irq_o && cfg_i.clock_source_select);
endmodule : clock_sync_serial_channel_assertions

// ### test/clock_sync_serial_channel_tb.sv
// self-checking bench for the serial channel and its far-side peer
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
    end \
  end

module clock_sync_serial_channel_tb
  import sync_serial_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  cfg_t cfg;
  cfg_t base;
  logic [7:0] tx_data_i = 8'h00;
  logic [7:0] peer_word = 8'h3c;
  logic tx_valid_i = 1'b0, rx_read_i = 1'b0, cts_n_i = 1'b1, ext_go = 1'b0;
  logic tx_ready_o, tx_irq_o, rx_irq_o, txd_o, txd_oe_o, sclk_o, sclk_oe_o;
  logic rts_n_o, rts_n_oe_o, rxd, ext_clk, peer_done;
  logic [7:0] rx_buffer_reg_o, peer_got, peer_sent, t;
  status_t status_o;
  wire logic sclk_wire = cfg.clock_source_select ? ext_clk : sclk_o;
  wire logic txd_wire = txd_oe_o ? txd_o : ~txd_o;
  int fail_count = 0, tests_run = 0, cyc = 0, tx_at, rx_at, rx_cnt = 0, pd_cnt = 0, pd_at;
  int k, n, r, p1;
  logic [7:0] txq[$];
  // {polarity, msb first, invert, irq source} divider data
  logic [23:0] tbl [4] = '{24'h0_0_03_96, 24'hd_0_02_3b, 24'h6_0_ff_c4, 24'h8_0_04_01};

  initial forever #2 clock_i = ~clock_i;

  clock_sync_serial_channel #(.CHANNEL(2)) clock_sync_serial_channel_i (.clock_i(clock_i),
    .rst_i(rst_i), .cfg_i(cfg), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .rx_read_i(rx_read_i), .rx_buffer_reg_o(rx_buffer_reg_o),
    .status_o(status_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
    .serial_clock_pin_i(sclk_wire), .serial_clock_pin_o(sclk_o),
    .serial_clock_pin_oe_o(sclk_oe_o), .serial_clock_alt_o(), .serial_clock_alt_oe_o(),
    .rxd_i(rxd), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .cts_n_i(cts_n_i), .rts_n_o(rts_n_o),
    .rts_n_oe_o(rts_n_oe_o), .pin_group_o());

  serial_peer_model serial_peer_model_i (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk_wire),
    .txd_i(txd_wire), .pol_i(cfg.clock_edge_polarity), .msb_i(cfg.msb_first),
    .ext_go_i(ext_go), .half_i(cfg.bit_rate_divider), .word_i(peer_word), .rxd_o(rxd),
    .ext_clk_o(ext_clk), .done_o(peer_done), .got_o(peer_got), .sent_o(peer_sent));

  // ------------
  // monitor of both directions
  // ------------
  always @(posedge clock_i)
  begin
    cyc++;
    if (tx_irq_o === 1'b1)
      tx_at = cyc;
    if (rx_irq_o === 1'b1)
    begin
      rx_at = cyc;
      rx_cnt++;
      `CHK("rx word", peer_sent ^ {8{cfg.invert_data}}, rx_buffer_reg_o);
      peer_word <= peer_word + 8'h37;
    end
    if (peer_done === 1'b1)
    begin
      pd_at = cyc;
      pd_cnt++;
      if (txq.size() > 0)
      begin
        t = txq.pop_front() ^ {8{cfg.invert_data}};
        `CHK("tx word", t, peer_got);
      end
    end
  end

  // ------------
  // access tasks
  // ------------
  task push(input logic [7:0] d);
    @(posedge clock_i);
    tx_data_i <= d;
    tx_valid_i <= 1'b1;
    txq.push_back(d);
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while (tx_ready_o !== 1'b1 && k < 20000);
    tx_valid_i <= 1'b0;
  endtask : push

  task wait_rx(input int m);
    for (k = 0; rx_cnt < m && k < 20000; k++)
      @(posedge clock_i);
    `CHK("rx count", m, rx_cnt);
  endtask : wait_rx

  task wait_pd(input int m);
    for (k = 0; pd_cnt < m && k < 20000; k++)
      @(posedge clock_i);
    `CHK("peer count", m, pd_cnt);
  endtask : wait_pd

  task read_rx();
    @(posedge clock_i);
    rx_read_i <= 1'b1;
    @(posedge clock_i);
    rx_read_i <= 1'b0;
  endtask : read_rx

  task end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // bounded run, well above the test length
  initial
  begin
    repeat (60000) @(posedge clock_i);
    fail_count++;
    end_of_test();
  end

  // ------------
  // scenarios
  // ------------
  initial
  begin
    base = '0;
    base.tx_enable_flag = 1'b1;
    base.rx_enable_flag = 1'b1;
    base.bit_rate_divider = 8'h02;
    cfg = base;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    // edge, order, inversion and irq source modes
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock_i);
      {cfg.clock_edge_polarity, cfg.msb_first, cfg.invert_data,
       cfg.tx_irq_source_select} <= tbl[i][23:20];
      cfg.bit_rate_divider <= tbl[i][15:8];
      repeat (4) @(posedge clock_i);
      push(tbl[i][7:0]);
      wait_rx(rx_cnt + 1);
      if (tbl[i][20])
        `CHK("done irq", tx_at, rx_at)
      else
        `CHK("frame span", 16 * (int'(tbl[i][15:8]) + 1), rx_at - tx_at)
      read_rx();
    end
    // chained words without reading: no gap, overrun, request kept
    @(posedge clock_i);
    cfg <= base;
    repeat (4) @(posedge clock_i);
    n = pd_cnt;
    r = rx_cnt;
    push(8'h5a);
    push(8'ha7);
    wait_pd(n + 1);
    p1 = pd_at;
    wait_pd(n + 2);
    `CHK("chain gap", 48, pd_at - p1);
    repeat (2) @(posedge clock_i);
    `CHK("overrun", 1'b1, status_o.overrun);
    `CHK("irq kept", r + 1, rx_cnt);
    // held transmit fills the fifo, then drains
    @(posedge clock_i);
    cfg.rx_enable_flag <= 1'b0;
    cfg.tx_enable_flag <= 1'b0;
    cfg.handshake_enable <= 1'b1;
    cfg.handshake_rts <= 1'b1;
    read_rx();
    for (int j = 0; j < 9; j++)
      push(8'h20 + 8'(j));
    repeat (3) @(posedge clock_i);
    `CHK("fifo full", 1'b0, tx_ready_o);
    `CHK("no start", n + 2, pd_cnt);
    `CHK("overrun clr", 1'b0, status_o.overrun);
    cfg.tx_enable_flag <= 1'b1;
    wait_pd(n + 11);
    `CHK("rx refused", r + 1, rx_cnt);
    // clear-to-send held high by the far side
    @(posedge clock_i);
    cfg.rx_enable_flag <= 1'b1;
    cfg.handshake_rts <= 1'b0;
    push(8'h6e);
    repeat (100) @(posedge clock_i);
    `CHK("cts wait", n + 11, pd_cnt);
    cts_n_i <= 1'b0;
    wait_rx(rx_cnt + 1);
    read_rx();
    // request-to-send follows the receive buffer
    cfg.handshake_rts <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK("rts ready", 2'b10, {rts_n_oe_o, rts_n_o});
    push(8'h81);
    wait_rx(rx_cnt + 1);
    repeat (2) @(posedge clock_i);
    `CHK("rts full", 1'b1, rts_n_o);
    // continuous receive: a read alone starts the next word
    cfg.continuous_rx <= 1'b1;
    cfg.handshake_enable <= 1'b0;
    read_rx();
    wait_rx(rx_cnt + 1);
    cfg.continuous_rx <= 1'b0;
    repeat (2) @(posedge clock_i);
    read_rx();
    // clock supplied by the far side
    cfg.clock_source_select <= 1'b1;
    repeat (4) @(posedge clock_i);
    `CHK("clk released", 1'b0, sclk_oe_o);
    push(8'hd2);
    repeat (4) @(posedge clock_i);
    ext_go <= 1'b1;
    @(posedge clock_i);
    ext_go <= 1'b0;
    wait_rx(rx_cnt + 1);
    repeat (10) @(posedge clock_i);
    end_of_test();
  end
endmodule : clock_sync_serial_channel_tb

bind clock_sync_serial_channel clock_sync_serial_channel_assertions
  clock_sync_serial_channel_assertions_i (.clock_i(clock_i), .rst_i(rst_i), .cfg_i(cfg_i),
  .status_o(status_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
  .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
  .txd_o(txd_o), .txd_oe_o(txd_oe_o), .cts_n_i(cts_n_i), .rts_n_o(rts_n_o));

// ### test/serial_peer_model.sv
// far-side clock synchronous serial peer
module serial_peer_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic txd_i,
  input wire logic pol_i,
  input wire logic msb_i,
  input wire logic ext_go_i,
  input wire logic [7:0] half_i,
  input wire logic [7:0] word_i,
  output logic rxd_o,
  output logic ext_clk_o,
  output logic done_o,
  output logic [7:0] got_o,
  output logic [7:0] sent_o
);
  logic prev_r;
  logic [3:0] dcnt_r;
  logic [3:0] scnt_r;
  logic [4:0] ecnt_r;
  logic [7:0] etick_r;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] w;
  logic drive;
  logic sample;
  // edge toward polarity level drives, edge back to idle samples
  assign drive = (sclk_i != prev_r) && (sclk_i == pol_i);
  assign sample = (sclk_i != prev_r) && (sclk_i != pol_i) && (dcnt_r != 4'h0);
  assign w = (dcnt_r == 4'h0) ? word_i : sent_o;
  assign shift_nxt = msb_i ? {shift_r[6:0], txd_i} : {txd_i, shift_r[7:1]};

  always_ff @(posedge clock_i)
  begin
    prev_r <= sclk_i;
    if (rst_i)
    begin
      dcnt_r <= 4'h0;
      rxd_o <= 1'b1;
      sent_o <= 8'h00;
    end
    else if (drive && dcnt_r < 4'h8)
    begin
      sent_o <= w;
      rxd_o <= msb_i ? w[3'h7 - dcnt_r[2:0]] : w[dcnt_r[2:0]];
      dcnt_r <= dcnt_r + 4'h1;
    end
    else if (sample && scnt_r == 4'h7)
    begin
      // released line shows a changed level
      dcnt_r <= 4'h0;
      rxd_o <= ~rxd_o;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      scnt_r <= 4'h0;
      done_o <= 1'b0;
      shift_r <= 8'h00;
      got_o <= 8'h00;
    end
    else
    begin
      done_o <= 1'b0;
      if (sample)
      begin
        shift_r <= shift_nxt;
        scnt_r <= (scnt_r == 4'h7) ? 4'h0 : scnt_r + 4'h1;
        if (scnt_r == 4'h7)
        begin
          done_o <= 1'b1;
          got_o <= shift_nxt;
        end
      end
    end
  end

  // supplied clock, idles opposite to polarity
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ecnt_r <= 5'h00;
      etick_r <= 8'h00;
      ext_clk_o <= 1'b1;
    end
    else if (ext_go_i)
    begin
      ecnt_r <= 5'h10;
      etick_r <= half_i;
    end
    else if (ecnt_r != 5'h00)
    begin
      etick_r <= (etick_r == 8'h00) ? half_i : etick_r - 8'h01;
      if (etick_r == 8'h00)
      begin
        ext_clk_o <= ~ext_clk_o;
        ecnt_r <= ecnt_r - 5'h01;
      end
    end
    else
      ext_clk_o <= ~pol_i;
  end
endmodule : serial_peer_model
